// ==== design/hdp_pkg.sv ====
// Shared constants and state types for the host DMA port, both ends
package hdp_pkg;
    localparam int DW         = 16;
    localparam int PROG_W     = 24;
    localparam int PTR_W      = 14;
    localparam int MEM_AW     = 8;
    localparam int MEM_DEPTH  = 256;
    localparam int SPACE_BIT  = 15;
    localparam int SRO_BIT    = 14;
    localparam int PROG_LO_W  = 8;
    localparam logic [PTR_W-1:0] OVL_ADDR = 14'h3fe7;
    localparam logic [DW-1:0]    OVL_RST  = 16'h0000;
    localparam logic [DW-1:0]    BUS_IDLE = 16'hffff;
    localparam int FIFO_W     = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int APB_AW     = 8;
    localparam logic [APB_AW-1:0] A_CTRL   = 8'h00;
    localparam logic [APB_AW-1:0] A_ADDR   = 8'h04;
    localparam logic [APB_AW-1:0] A_WDATA  = 8'h08;
    localparam logic [APB_AW-1:0] A_RCMD   = 8'h0c;
    localparam logic [APB_AW-1:0] A_RDATA  = 8'h10;
    localparam logic [APB_AW-1:0] A_STATUS = 8'h14;
    localparam int CTRL_SRO  = 0;
    localparam int ST_BUSY   = 0;
    localparam int ST_RDV    = 1;
    localparam int ST_EMPTY  = 2;
    localparam int ST_FULL   = 3;
    typedef enum logic [1:0] {K_LATCH = 2'b00, K_WRITE = 2'b01, K_READ = 2'b10} kind_t;
    typedef enum logic [2:0] {
        D_IDLE = 3'b000, D_LATCH = 3'b001, D_WRITE = 3'b010,
        D_RDFETCH = 3'b011, D_RDHOLD = 3'b100, D_POST = 3'b101
    } dev_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_PHASE = 3'b001, H_RDLOW = 3'b010, H_WAIT_HI = 3'b011
    } host_state_t;
endpackage

// ==== design/host_dma_device.sv ====
// DSP end of the host DMA port: pin handshake, overlay register, memories
// Operation
// - write starts when select and write strobe low
// - read spans select and read strobe low
// - bit 14 of overlay 0x3FE7, reset off
// - core and host may both write that bit
// - short-read-only drives prefetched word whole read
// - host clears that bit before ordinary short reads
// - host prefers short-read-only at high clock rates
// - data word one read, program word two halves
// - long read: data driven on the same edge ack goes low, host waits
// - mode strap caught at reset release, held
// - strap one hands pins to host port
// - latch phase is select low, latch high
`timescale 1ns/1ps
`default_nettype none
module host_dma_device (
    input  wire logic               core_clk,
    input  wire logic               srst,
    host_port_if.device             port,
    input  wire logic               host_mode_strap,
    input  wire logic               core_ovl_wr,
    input  wire logic [hdp_pkg::DW-1:0] core_ovl_wdata,
    output logic                    host_mode,
    output logic [hdp_pkg::DW-1:0]  overlay_ctrl
);
    import hdp_pkg::*;

    logic [PROG_W-1:0] program_memory [MEM_DEPTH];
    logic [DW-1:0]     data_memory [MEM_DEPTH];

    // Two-flop synchronisers on every pin
    logic [3:0]    pin_s1_r, pin_s2_r;
    logic [DW-1:0] bus_s1_r, bus_s2_r;
    logic          strap_s1_r, strap_s2_r, rst_d_r;

    always_ff @(posedge core_clk) begin
        pin_s1_r   <= {port.host_port_select_n, port.host_read_strobe_n,
                       port.host_write_strobe_n, port.host_address_latch};
        pin_s2_r   <= pin_s1_r;
        bus_s1_r   <= port.host_addr_data_bus;
        bus_s2_r   <= bus_s1_r;
        strap_s1_r <= host_mode_strap;
        strap_s2_r <= strap_s1_r;
    end

    logic sel_n_s, rd_n_s, wr_n_s, al_s;
    logic start_al, start_wr, start_rd;
    always_comb begin
        {sel_n_s, rd_n_s, wr_n_s, al_s} = pin_s2_r;
        start_al = !sel_n_s && al_s;
        start_wr = !sel_n_s && !wr_n_s;
        start_rd = !sel_n_s && !rd_n_s;
    end

    // Word seen by the host for a given space, address and half
    function automatic logic [DW-1:0] fetch_word(input logic prog, input logic [PTR_W-1:0] a,
                                                 input logic half, input logic [DW-1:0] ovl);
        logic [PROG_W-1:0] pw;
        pw = program_memory[a[MEM_AW-1:0]];
        if (prog) begin
            fetch_word = half ? {{(DW-PROG_LO_W){1'b0}}, pw[PROG_LO_W-1:0]}
                              : pw[PROG_W-1:PROG_LO_W];
        end else if (a == OVL_ADDR) begin
            fetch_word = ovl;
        end else begin
            fetch_word = data_memory[a[MEM_AW-1:0]];
        end
    endfunction

    dev_state_t       state_r, state_nxt;
    kind_t            kind_r, kind_nxt;
    logic [PTR_W-1:0] ptr_r, ptr_nxt;
    logic             space_r, space_nxt, half_r, half_nxt;
    logic [DW-1:0]    lat_r, lat_nxt, wdat_r, wdat_nxt, out_r, out_nxt;
    logic [DW-1:0]    ovl_r, ovl_nxt, prog_hi_r, prog_hi_nxt;
    logic             ack_n_r, ack_n_nxt, oe_r, oe_nxt, mode_r, mode_nxt;
    logic             data_we, prog_we, sro;

    // Port state machine and all side effects of an access
    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        ptr_nxt   = ptr_r;
        space_nxt = space_r;
        half_nxt  = half_r;
        lat_nxt   = lat_r;
        wdat_nxt  = wdat_r;
        out_nxt   = out_r;
        prog_hi_nxt = prog_hi_r;
        ovl_nxt   = ovl_r;
        data_we   = 1'b0;
        prog_we   = 1'b0;
        sro       = ovl_r[SRO_BIT];
        mode_nxt  = (rst_d_r && !srst) ? strap_s2_r : mode_r;
        if (core_ovl_wr) begin
            ovl_nxt = core_ovl_wdata;
        end
        case (state_r)
            D_IDLE: begin
                if (mode_r) begin
                    if (start_al) begin
                        state_nxt = D_LATCH;
                    end else if (start_wr) begin
                        state_nxt = D_WRITE;
                    end else if (start_rd) begin
                        state_nxt = D_RDFETCH;
                    end
                end
            end
            D_LATCH: begin
                if (start_al) begin
                    lat_nxt = bus_s2_r;
                end else begin
                    kind_nxt  = K_LATCH;
                    state_nxt = D_POST;
                end
            end
            D_WRITE: begin
                if (start_wr) begin
                    wdat_nxt = bus_s2_r; // Last sample before strobe rises
                end else begin
                    kind_nxt  = K_WRITE;
                    state_nxt = D_POST;
                end
            end
            D_RDFETCH: begin
                if (!sro) begin
                    out_nxt = fetch_word(space_r, ptr_r, half_r, ovl_r);
                end
                state_nxt = D_RDHOLD;
            end
            D_RDHOLD: begin
                if (!start_rd) begin
                    kind_nxt  = K_READ;
                    state_nxt = D_POST;
                end
            end
            D_POST: begin
                state_nxt = D_IDLE;
                case (kind_r)
                    K_LATCH: begin
                        ptr_nxt   = lat_r[PTR_W-1:0];
                        space_nxt = lat_r[SPACE_BIT];
                        half_nxt  = 1'b0;
                    end
                    K_WRITE: begin
                        if (!space_r) begin
                            if (ptr_r == OVL_ADDR) begin
                                ovl_nxt = wdat_r;
                            end else begin
                                data_we = 1'b1;
                            end
                            ptr_nxt = ptr_r + 1'b1;
                        end else if (!half_r) begin
                            prog_hi_nxt = wdat_r;
                            half_nxt  = 1'b1;
                        end else begin
                            prog_we  = 1'b1;
                            half_nxt = 1'b0;
                            ptr_nxt  = ptr_r + 1'b1;
                        end
                    end
                    K_READ: begin
                        if (space_r && !half_r) begin
                            half_nxt = 1'b1;
                        end else begin
                            half_nxt = 1'b0;
                            ptr_nxt  = ptr_r + 1'b1;
                        end
                    end
                    default: ptr_nxt = ptr_r;
                endcase
                // Prefetch for the next short-read-only access
                out_nxt = fetch_word(space_nxt, ptr_nxt, half_nxt, ovl_nxt);
            end
            default: state_nxt = D_IDLE;
        endcase
        // Ack high while busy; data enabled from read start in sro mode
        ack_n_nxt = !mode_nxt || !((state_nxt == D_IDLE) || (state_nxt == D_RDHOLD));
        oe_nxt    = (state_nxt == D_RDHOLD) || ((state_nxt == D_RDFETCH) && sro);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= D_IDLE;
            kind_r  <= K_LATCH;
            ptr_r   <= '0;
            space_r <= 1'b0;
            half_r  <= 1'b0;
            lat_r   <= '0;
            wdat_r  <= '0;
            out_r   <= '0;
            prog_hi_r <= '0;
            ovl_r   <= OVL_RST;
            ack_n_r <= 1'b1;
            oe_r    <= 1'b0;
            mode_r  <= 1'b0;
            rst_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            ptr_r   <= ptr_nxt;
            space_r <= space_nxt;
            half_r  <= half_nxt;
            lat_r   <= lat_nxt;
            wdat_r  <= wdat_nxt;
            out_r   <= out_nxt;
            prog_hi_r <= prog_hi_nxt;
            ovl_r   <= ovl_nxt;
            ack_n_r <= ack_n_nxt;
            oe_r    <= oe_nxt;
            mode_r  <= mode_nxt;
            rst_d_r <= 1'b0;
        end
    end

    // Memories are not cleared by reset
    always_ff @(posedge core_clk) begin
        if (data_we) begin
            data_memory[ptr_r[MEM_AW-1:0]] <= wdat_r;
        end
        if (prog_we) begin
            program_memory[ptr_r[MEM_AW-1:0]] <= {prog_hi_r, wdat_r[PROG_LO_W-1:0]};
        end
    end

    assign port.host_access_ack_n = ack_n_r;
    assign port.dev_bus_o         = out_r;
    assign port.dev_bus_oe        = oe_r;
    assign host_mode              = mode_r;
    assign overlay_ctrl           = ovl_r;
endmodule
`default_nettype wire

// ==== design/host_dma_host.sv ====
// Host end: APB-controlled engine driving the DSP host DMA port
`timescale 1ns/1ps
`default_nettype none
module host_dma_host (
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    host_port_if.host                       port,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [hdp_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr
);
    import hdp_pkg::*;

    logic              fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;

    // Write data queue; full FIFO stalls APB via pready
    sync_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[FIFO_W-1:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Pin inputs from the device pass two flops
    logic          ack_s1_r, ack_s_r;
    logic [DW-1:0] bus_s1_r, bus_s_r;
    always_ff @(posedge core_clk) begin
        ack_s1_r <= port.host_access_ack_n;
        ack_s_r  <= ack_s1_r;
        bus_s1_r <= port.host_addr_data_bus;
        bus_s_r  <= bus_s1_r;
    end

    host_state_t   st_r, st_nxt;
    kind_t         kind_r, kind_nxt;
    logic          sel_n_r, sel_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, al_r, al_nxt;
    logic [DW-1:0] bo_r, bo_nxt, lat_val_r, lat_val_nxt, rdata_r, rdata_nxt;
    logic          boe_r, boe_nxt, lat_pend_r, lat_pend_nxt, rd_pend_r, rd_pend_nxt;
    logic          rdv_r, rdv_nxt, sro_r, sro_nxt;
    logic          pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0]   prdata_r, prdata_nxt;
    logic          acc, done, ok, busy;

    always_comb begin
        acc           = psel && penable;
        done          = acc && pready_r;
        busy          = (st_r != H_IDLE) || lat_pend_r || rd_pend_r || fifo_out_valid || ack_s_r;
        st_nxt        = st_r;
        kind_nxt      = kind_r;
        sel_n_nxt     = sel_n_r;
        rd_n_nxt      = rd_n_r;
        wr_n_nxt      = wr_n_r;
        al_nxt        = al_r;
        bo_nxt        = bo_r;
        boe_nxt       = boe_r;
        lat_val_nxt   = lat_val_r;
        lat_pend_nxt  = lat_pend_r;
        rd_pend_nxt   = rd_pend_r;
        rdata_nxt     = rdata_r;
        rdv_nxt       = rdv_r;
        sro_nxt       = sro_r;
        fifo_out_ready = 1'b0;
        // APB slave: one wait state, longer while the target is occupied
        ok            = 1'b1;
        prdata_nxt    = '0;
        pslverr_nxt   = 1'b0;
        case (paddr)
            A_WDATA: ok = !pwrite || fifo_in_ready;
            A_ADDR:  ok = !pwrite || !lat_pend_r;
            A_RCMD:  ok = !pwrite || !rd_pend_r;
            default: ok = 1'b1;
        endcase
        pready_nxt = acc && !pready_r && ok;
        if (pready_nxt && !pwrite) begin
            case (paddr)
                A_CTRL:   prdata_nxt[CTRL_SRO] = sro_r;
                A_RDATA:  prdata_nxt[DW-1:0] = rdata_r;
                A_STATUS: begin
                    prdata_nxt[ST_BUSY]  = busy;
                    prdata_nxt[ST_RDV]   = rdv_r;
                    prdata_nxt[ST_EMPTY] = !fifo_out_valid;
                    prdata_nxt[ST_FULL]  = !fifo_in_ready;
                end
                A_ADDR, A_WDATA, A_RCMD: prdata_nxt = '0;
                default:  pslverr_nxt = 1'b1;
            endcase
        end else if (pready_nxt) begin
            pslverr_nxt = !((paddr == A_CTRL) || (paddr == A_ADDR) ||
                            (paddr == A_WDATA) || (paddr == A_RCMD));
        end
        fifo_in_valid = done && pwrite && (paddr == A_WDATA);
        if (done && pwrite) begin
            case (paddr)
                A_CTRL: sro_nxt = pwdata[CTRL_SRO];
                A_ADDR: begin
                    lat_pend_nxt = 1'b1;
                    lat_val_nxt  = pwdata[DW-1:0];
                end
                A_RCMD: begin
                    rd_pend_nxt = 1'b1;
                    rdv_nxt     = 1'b0;
                end
                default: sro_nxt = sro_r;
            endcase
        end
        // Pin engine: every phase waits for ack high, then ack low again
        case (st_r)
            H_IDLE: begin
                if (!ack_s_r) begin
                    if (lat_pend_r) begin
                        kind_nxt     = K_LATCH;
                        lat_pend_nxt = 1'b0;
                        sel_n_nxt    = 1'b0;
                        al_nxt       = 1'b1;
                        bo_nxt       = lat_val_r;
                        boe_nxt      = 1'b1;
                        st_nxt       = H_PHASE;
                    end else if (fifo_out_valid) begin
                        kind_nxt       = K_WRITE;
                        fifo_out_ready = 1'b1;
                        sel_n_nxt      = 1'b0;
                        wr_n_nxt       = 1'b0;
                        bo_nxt         = fifo_out_data;
                        boe_nxt        = 1'b1;
                        st_nxt         = H_PHASE;
                    end else if (rd_pend_r) begin
                        kind_nxt    = K_READ;
                        rd_pend_nxt = 1'b0;
                        sel_n_nxt   = 1'b0;
                        rd_n_nxt    = 1'b0;
                        st_nxt      = H_PHASE;
                    end
                end
            end
            H_PHASE: begin
                if (ack_s_r) begin
                    if ((kind_r == K_READ) && !sro_r) begin
                        st_nxt = H_RDLOW;
                    end else begin
                        if (kind_r == K_READ) begin
                            rdata_nxt = bus_s_r;
                            rdv_nxt   = 1'b1;
                        end
                        st_nxt = H_WAIT_HI;
                    end
                end
            end
            H_RDLOW: begin
                if (!ack_s_r) begin
                    rdata_nxt = bus_s_r;
                    rdv_nxt   = 1'b1;
                    st_nxt    = H_WAIT_HI;
                end
            end
            H_WAIT_HI: begin
                if (ack_s_r) begin
                    st_nxt = H_IDLE;
                end
            end
            default: st_nxt = H_IDLE;
        endcase
        if ((st_nxt == H_WAIT_HI) && (st_r != H_WAIT_HI)) begin
            sel_n_nxt = 1'b1;
            rd_n_nxt  = 1'b1;
            wr_n_nxt  = 1'b1;
            al_nxt    = 1'b0;
            boe_nxt   = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r       <= H_IDLE;
            kind_r     <= K_LATCH;
            sel_n_r    <= 1'b1;
            rd_n_r     <= 1'b1;
            wr_n_r     <= 1'b1;
            al_r       <= 1'b0;
            bo_r       <= '0;
            boe_r      <= 1'b0;
            lat_val_r  <= '0;
            lat_pend_r <= 1'b0;
            rd_pend_r  <= 1'b0;
            rdata_r    <= '0;
            rdv_r      <= 1'b0;
            sro_r      <= 1'b0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            prdata_r   <= '0;
        end else begin
            st_r       <= st_nxt;
            kind_r     <= kind_nxt;
            sel_n_r    <= sel_n_nxt;
            rd_n_r     <= rd_n_nxt;
            wr_n_r     <= wr_n_nxt;
            al_r       <= al_nxt;
            bo_r       <= bo_nxt;
            boe_r      <= boe_nxt;
            lat_val_r  <= lat_val_nxt;
            lat_pend_r <= lat_pend_nxt;
            rd_pend_r  <= rd_pend_nxt;
            rdata_r    <= rdata_nxt;
            rdv_r      <= rdv_nxt;
            sro_r      <= sro_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            prdata_r   <= prdata_nxt;
        end
    end

    assign port.host_port_select_n  = sel_n_r;
    assign port.host_read_strobe_n  = rd_n_r;
    assign port.host_write_strobe_n = wr_n_r;
    assign port.host_address_latch  = al_r;
    assign port.host_bus_o          = bo_r;
    assign port.host_bus_oe         = boe_r;
    assign prdata                   = prdata_r;
    assign pready                   = pready_r;
    assign pslverr                  = pslverr_r;
endmodule
`default_nettype wire

// ==== design/host_port_if.sv ====
// Pin bundle between the host processor and the DSP host DMA port
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
    import hdp_pkg::*;
    logic          host_port_select_n;
    logic          host_read_strobe_n;
    logic          host_write_strobe_n;
    logic          host_address_latch;
    logic          host_access_ack_n;
    logic [DW-1:0] host_bus_o;
    logic          host_bus_oe;
    logic [DW-1:0] dev_bus_o;
    logic          dev_bus_oe;
    logic [DW-1:0] host_addr_data_bus;
    // Resolved wire level, pulled up when nobody drives
    assign host_addr_data_bus = dev_bus_oe ? dev_bus_o : (host_bus_oe ? host_bus_o : BUS_IDLE);
    modport device (
        input  host_port_select_n, host_read_strobe_n, host_write_strobe_n,
        input  host_address_latch, host_addr_data_bus,
        output host_access_ack_n, dev_bus_o, dev_bus_oe
    );
    modport host (
        output host_port_select_n, host_read_strobe_n, host_write_strobe_n,
        output host_address_latch, host_bus_o, host_bus_oe,
        input  host_access_ack_n, host_addr_data_bus
    );
endinterface
`default_nettype wire

// ==== design/sync_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic        push, pop;

    // Extra pointer bit tells full from empty
    always_comb begin
        in_ready  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
        out_valid = (wp_r != rp_r);
        out_data  = mem[rp_r[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_nxt    = push ? wp_r + 1'b1 : wp_r;
        rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // Storage has no reset; empty flag guards stale words
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/host_dma_port_access_assertions.sv ====
// Link checks between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module host_dma_port_access_assertions (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        host_port_select_n,
    input wire logic        host_read_strobe_n,
    input wire logic        host_write_strobe_n,
    input wire logic        host_address_latch,
    input wire logic        host_access_ack_n,
    input wire logic        host_bus_oe,
    input wire logic        dev_bus_oe,
    input wire logic [15:0] dev_bus_o
);
    // Phase decodes from the raw pins
    wire logic wr_on = !host_port_select_n && !host_write_strobe_n;
    wire logic rd_on = !host_port_select_n && !host_read_strobe_n;
    wire logic la_on = !host_port_select_n && host_address_latch;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    AST_WR_ACK: assert property ($rose(wr_on) && !host_access_ack_n |-> ##[2:4] host_access_ack_n)
        else $error("write start not answered");
    AST_RD_ACK: assert property ($rose(rd_on) && !host_access_ack_n |-> ##[2:4] host_access_ack_n)
        else $error("read start not answered");
    AST_LA_ACK: assert property ($rose(la_on) && !host_access_ack_n |-> ##[2:4] host_access_ack_n)
        else $error("latch start not answered");
    AST_RD_END: assert property ($fell(rd_on) |-> ##[1:4] !dev_bus_oe)
        else $error("bus still driven after read end");
    AST_OE_START: assert property ($rose(dev_bus_oe) |-> rd_on)
        else $error("bus driven outside a read");
    AST_LONG_DATA: assert property ($fell(host_access_ack_n) && rd_on |-> dev_bus_oe)
        else $error("ack low without read data");
    AST_DATA_HOLD: assert property (dev_bus_oe && $past(dev_bus_oe) |-> $stable(dev_bus_o))
        else $error("read data changed while driven");
    AST_NO_CLASH: assert property (!(dev_bus_oe && host_bus_oe))
        else $error("both ends drive the bus");
    // Main traffic kinds
    cover property ($rose(wr_on));
    cover property ($rose(la_on));
    cover property ($rose(dev_bus_oe));
endmodule
`default_nettype wire

// ==== testbench/host_dma_port_access_test.sv ====
// Bench joining both port ends, driven through APB
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module host_dma_port_access_test;
    import hdp_pkg::*;
    logic        core_clk, srst, psel, penable, pwrite, strap, ovl_wr, pready, pslverr, err;
    logic        host_mode;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] ovl_wd, ovl, a, b, exp_w;
    logic [23:0] pw;
    logic [15:0] exp_q[$];
    int          fail_count, checked, seed;
    host_port_if link ();
    host_dma_device u_host_dma_device (.core_clk, .srst, .port(link), .host_mode_strap(strap),
        .core_ovl_wr(ovl_wr), .core_ovl_wdata(ovl_wd), .host_mode, .overlay_ctrl(ovl));
    host_dma_host u_host_dma_host (.core_clk, .srst, .port(link), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    host_dma_port_access_assertions u_chk (.core_clk, .srst,
        .host_port_select_n(link.host_port_select_n), .host_read_strobe_n(link.host_read_strobe_n),
        .host_write_strobe_n(link.host_write_strobe_n), .host_address_latch(link.host_address_latch),
        .host_access_ack_n(link.host_access_ack_n), .host_bus_oe(link.host_bus_oe),
        .dev_bus_oe(link.dev_bus_oe), .dev_bus_o(link.dev_bus_o));
    always #50 core_clk = ~core_clk;
    // One APB transfer; no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Poll until the engine settles
    task automatic idle(input logic rv);
        repeat (300) begin
            apb(1'b0, A_STATUS, '0);
            if (!rd[ST_BUSY] && (rd[ST_RDV] || !rv)) return;
        end
        fail_count++; // Engine never settled
    endtask
    task automatic rword(input logic [15:0] e);
        apb(1'b1, A_RCMD, '0);
        idle(1'b1);
        exp_q.push_back(e);
        apb(1'b0, A_RDATA, '0);
    endtask
    task automatic core_wr(input logic [15:0] d);
        @(posedge core_clk);
        {ovl_wr, ovl_wd} <= {1'b1, d};
        @(posedge core_clk);
        ovl_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Read data checker, oldest note first
    always @(posedge core_clk)
        if (psel && penable && pready && !pwrite && paddr == A_RDATA && exp_q.size() > 0) begin
            exp_w = exp_q.pop_front();
            `CHK(prdata[15:0], exp_w)
        end
    // Watchdog, well past the expected run
    initial begin
        #(100 * 40000);
        fail_count++;
        tally_and_finish;
    end
    initial begin
        {core_clk, srst, psel, penable, pwrite, strap, ovl_wr, paddr, pwdata, ovl_wd} = '0;
        srst = 1'b1;
        strap = 1'b1;
        seed = 32'hff26;
        {a, b} = $random(seed);
        pw = 24'($random(seed));
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK(host_mode, 1'b1)
        `CHK(ovl, OVL_RST)
        apb(1'b1, A_ADDR, 32'h0000_0010);
        apb(1'b1, A_WDATA, {16'h0000, a});
        apb(1'b1, A_WDATA, {16'h0000, b});
        idle(1'b0);
        apb(1'b1, A_ADDR, 32'h0000_0010);
        rword(a);
        rword(b);
        apb(1'b1, A_ADDR, 32'h0000_8020);
        apb(1'b1, A_WDATA, {16'h0000, pw[23:8]});
        apb(1'b1, A_WDATA, {24'h00_0000, pw[7:0]});
        idle(1'b0);
        apb(1'b1, A_ADDR, 32'h0000_8020);
        rword(pw[23:8]);
        rword({8'h00, pw[7:0]});
        $display("memory test done");
        apb(1'b1, A_ADDR, 32'h0000_3fe7);
        apb(1'b1, A_WDATA, 32'h0000_4000);
        idle(1'b0);
        `CHK(ovl[SRO_BIT], 1'b1)
        core_wr(16'h0000);
        `CHK(ovl, 16'h0000)
        core_wr(16'h4000);
        apb(1'b1, A_CTRL, 32'h0000_0001);
        apb(1'b1, A_ADDR, 32'h0000_0010);
        rword(a);
        core_wr(16'h0000);
        apb(1'b1, A_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h18, '0);
        `CHK(err, 1'b1)
        $display("overlay test done");
        // Strap low mutes the device, so the buffer can only fill
        {strap, srst} <= 2'b01;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        repeat (20) begin
            apb(1'b0, A_STATUS, '0);
            if (rd[ST_FULL]) break;
            apb(1'b1, A_WDATA, {16'h0000, a});
        end
        `CHK(rd[ST_FULL], 1'b1)
        `CHK(link.host_access_ack_n, 1'b1)
        $display("strap test done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
